/* File: rtl/vlm_pkg.sv */
/*
 * constants, register map and types of the video link mode and strap loader.
 * assumes one 250 MHz clock domain; strap levels come from an external quantizer.
 */
package vlm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VLM_BRIDGE_CONTROL_OFS = 8'h4f;
    localparam logic [7:0] VLM_BRIDGE_CFG_OFS = 8'h54;
    localparam logic [7:0] VLM_DUAL_CTL_OFS   = 8'h5b;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int VLM_DISPID_BIT   = 0;
    localparam int VLM_AUX_BIT      = 1;
    localparam int VLM_RDID_BIT     = 5;
    localparam int VLM_EXT_BIT      = 7;
    localparam int VLM_FSINGLE_BIT  = 0;
    localparam int VLM_FDUAL_BIT    = 1;
    localparam int VLM_AUTO_OFF_BIT = 2;
    localparam int VLM_PLLRST_BIT   = 5;
    localparam int VLM_CABLE_TYPE_SELECT_BIT     = 7;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] VLM_CTL_RST  = 8'h00;
    localparam logic [7:0] VLM_CFG_RST  = 8'h00;
    localparam logic [7:0] VLM_DUAL_RST = 8'h20;
    localparam logic [6:0] VLM_ADDR_BASE = 7'h0c;
    localparam logic [2:0] VLM_SETTLE    = 3'h4;
    localparam logic [7:0] VLM_SINGLE_MAX_MHZ = 8'h60;
    localparam logic [7:0] VLM_LEGACY_MAX_MHZ = 8'h55;
    localparam logic [7:0] VLM_DUAL_MAX_MHZ   = 8'haa;
    localparam logic [7:0] VLM_DUAL_MIN_MHZ   = 8'h61;
    // ------------------------------------------------------------
    // link modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VLM_IDLE,
        VLM_SINGLE,
        VLM_SECONDARY,
        VLM_DUAL,
        VLM_REPLICATE
    } vlm_mode_t;
endpackage : vlm_pkg

/* File: rtl/vlm_mode_strap.sv */
/*
 * startup strap loader and serial link topology selector with pixel steering.
 * assumes the serial control engine outside drives the register port on clk_in,
 * strap levels arrive as 3-bit indices from a quantizer, and the pixel clock
 * frequency is measured elsewhere and given in MHz on this clock.
 */
`timescale 1ns/1ps
module vlm_mode_strap
    import vlm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // strap level indices and receiver detection pins
    input  wire logic [2:0]  first_mode_strap_in,
    input  wire logic [2:0]  second_mode_strap_in,
    input  wire logic [2:0]  address_strap_pin_in,
    input  wire logic        rx_primary_present_in,
    input  wire logic        rx_secondary_present_in,
    input  wire logic        rx_dual_capable_in,
    input  wire logic [7:0]  pclk_mhz_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    output logic             reg_rvalid_out,
    // pixel stream
    input  wire logic [23:0] pix_data_in,
    input  wire logic        pix_valid_in,
    output logic      [23:0] link_a_data_out,
    output logic             link_a_valid_out,
    output logic      [23:0] link_b_data_out,
    output logic             link_b_valid_out,
    // configuration outputs
    output vlm_mode_t        link_mode_out,
    output logic             secondary_link_enable_out,
    output logic             cable_cable_type_select_out,
    output logic             external_input_override_out,
    output logic             pll_reset_out,
    output logic      [6:0]  bus_address_out,
    output logic             straps_latched_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  s0_a, s0_b, s0_c, s0_q;
        logic [2:0]  s1_a, s1_b, s1_c, s1_q;
        logic [2:0]  id_a, id_b, id_c, id_q;
        logic [2:0]  p_a, p_b, p_c, p_q;
        logic [2:0]  settle;
        logic        latched;
        logic [7:0]  ctl;
        logic [7:0]  cfg;
        logic [7:0]  dual;
        logic [6:0]  addr;
        vlm_mode_t   mode;
        logic [7:0]  mhz_last;
        logic        pll_rst;
        logic        phase;
        logic [23:0] pa_data;
        logic        pa_vld;
        logic [23:0] pb_data;
        logic        pb_vld;
        logic [7:0]  rdata;
        logic        rvld;
        logic        sec_en;
    } vlm_state_t;

    localparam vlm_state_t RST_S = '{ctl: VLM_CTL_RST, cfg: VLM_CFG_RST,
                                     dual: VLM_DUAL_RST, mode: VLM_IDLE,
                                     sec_en: 1'b1, default: '0};

    logic       rst_m_r;
    logic       rst_n_r;
    vlm_state_t r;
    vlm_state_t n;
    logic       auto_off;
    logic       go_latch;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    assign auto_off = r.dual[VLM_AUTO_OFF_BIT];
    assign go_latch = !r.latched && (r.settle == VLM_SETTLE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        // pins pass three stages; a level counts once the last two agree
        n.s0_a = first_mode_strap_in;
        n.s0_b = r.s0_a;
        n.s0_c = r.s0_b;
        n.s1_a = second_mode_strap_in;
        n.s1_b = r.s1_a;
        n.s1_c = r.s1_b;
        n.id_a = address_strap_pin_in;
        n.id_b = r.id_a;
        n.id_c = r.id_b;
        n.p_a  = {rx_dual_capable_in, rx_secondary_present_in, rx_primary_present_in};
        n.p_b  = r.p_a;
        n.p_c  = r.p_b;
        if (r.s0_b == r.s0_c) n.s0_q = r.s0_c;
        if (r.s1_b == r.s1_c) n.s1_q = r.s1_c;
        if (r.id_b == r.id_c) n.id_q = r.id_c;
        if (r.p_b == r.p_c) n.p_q = r.p_c;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                VLM_BRIDGE_CONTROL_OFS: n.ctl  = reg_wdata_in;
                VLM_BRIDGE_CFG_OFS: n.cfg  = reg_wdata_in;
                VLM_DUAL_CTL_OFS:   n.dual = reg_wdata_in;
                default: ;
            endcase
        end

        // one capture after the strap stages settle, never again
        if (!r.latched && !go_latch) n.settle = r.settle + 3'h1;
        if (go_latch) begin
            n.latched                = 1'b1;
            n.ctl[VLM_DISPID_BIT]    = r.s0_q[1];
            n.cfg[VLM_AUX_BIT]       = r.s0_q[0];
            // level index minus one is already the index itself
            n.cfg[VLM_EXT_BIT]       = r.s1_q[2];
            n.dual[VLM_CABLE_TYPE_SELECT_BIT]     = r.s1_q[1];
            n.cfg[VLM_RDID_BIT]      = r.s1_q[0];
            n.addr = VLM_ADDR_BASE + {3'h0, r.id_q, 1'b0};
        end

        // read port answers the cycle after the strobe; unmapped reads zero
        n.rvld  = reg_rd_in;
        n.rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                VLM_BRIDGE_CONTROL_OFS: n.rdata = r.ctl;
                VLM_BRIDGE_CFG_OFS: n.rdata = r.cfg;
                VLM_DUAL_CTL_OFS:   n.rdata = r.dual;
                default:            n.rdata = 8'h00;
            endcase
        end

        // topology choice
        if (!r.latched) begin
            n.mode = VLM_IDLE;
        end else if (auto_off) begin
            // forced dual wins; forced single or nothing forced runs single
            n.mode = r.dual[VLM_FDUAL_BIT] ? VLM_DUAL : VLM_SINGLE;
        end else if (r.p_q[0] && r.p_q[2] && pclk_mhz_in >= VLM_DUAL_MIN_MHZ) begin
            n.mode = VLM_DUAL;
        end else if (r.p_q[0] && r.p_q[1] && !r.p_q[2]) begin
            n.mode = VLM_REPLICATE;
        end else if (r.p_q[0]) begin
            n.mode = VLM_SINGLE;
        end else if (r.p_q[1]) begin
            n.mode = VLM_SECONDARY;
        end else begin
            n.mode = VLM_IDLE;
        end
        // secondary transmitter and back channel off only when single is forced
        n.sec_en = !(auto_off && r.dual[VLM_FSINGLE_BIT]);

        // pll restart pulse on a frequency step while the feature is on
        n.mhz_last = pclk_mhz_in;
        n.pll_rst  = r.latched && r.dual[VLM_PLLRST_BIT] && (pclk_mhz_in != r.mhz_last);

        // pixel steering; dual alternation halves each port's rate
        n.pa_vld = 1'b0;
        n.pb_vld = 1'b0;
        if (r.mode != VLM_DUAL) n.phase = 1'b0;
        if (pix_valid_in) begin
            case (r.mode)
                VLM_SINGLE: begin
                    n.pa_data = pix_data_in;
                    n.pa_vld  = 1'b1;
                end
                VLM_SECONDARY: begin
                    n.pb_data = pix_data_in;
                    n.pb_vld  = 1'b1;
                end
                VLM_REPLICATE: begin
                    n.pa_data = pix_data_in;
                    n.pa_vld  = 1'b1;
                    n.pb_data = pix_data_in;
                    n.pb_vld  = 1'b1;
                end
                VLM_DUAL: begin
                    n.phase = !r.phase;
                    if (r.phase) begin
                        n.pb_data = pix_data_in;
                        n.pb_vld  = 1'b1;
                    end else begin
                        n.pa_data = pix_data_in;
                        n.pa_vld  = 1'b1;
                    end
                end
                default: ;   // idle sends nothing
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) r <= RST_S;
        else r <= n;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out    = r.rdata;
    assign reg_rvalid_out   = r.rvld;
    assign link_a_data_out  = r.pa_data;
    assign link_a_valid_out = r.pa_vld;
    assign link_b_data_out  = r.pb_data;
    assign link_b_valid_out = r.pb_vld;
    assign link_mode_out    = r.mode;
    assign secondary_link_enable_out   = r.sec_en;
    assign cable_cable_type_select_out              = r.dual[VLM_CABLE_TYPE_SELECT_BIT];
    assign external_input_override_out = r.cfg[VLM_EXT_BIT];
    assign pll_reset_out      = r.pll_rst;
    assign bus_address_out    = r.addr;
    assign straps_latched_out = r.latched;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_r);

    dual_alt_a: assert property (
        r.mode == VLM_DUAL && pix_valid_in |=> r.pa_vld != r.pb_vld)
        else $error("dual pixel not on exactly one link");
    dual_swap_a: assert property (
        r.mode == VLM_DUAL && pix_valid_in ##1 r.mode == VLM_DUAL && pix_valid_in
        |=> r.pb_vld == $past(r.pa_vld))
        else $error("dual links did not alternate");
    forced_single_a: assert property (
        r.latched && auto_off && r.dual[VLM_FSINGLE_BIT] && !r.dual[VLM_FDUAL_BIT]
        |=> r.mode == VLM_SINGLE && !r.sec_en)
        else $error("forced single left secondary on");
    idle_quiet_a: assert property (
        r.mode == VLM_IDLE |=> !r.pa_vld && !r.pb_vld)
        else $error("idle mode sent pixels");
    replicate_same_a: assert property (
        r.mode == VLM_REPLICATE && pix_valid_in
        |=> r.pa_vld && r.pb_vld && r.pa_data == r.pb_data)
        else $error("replicate links differ");
    addr_latch_a: assert property (
        $rose(r.latched) |-> r.addr == VLM_ADDR_BASE + {3'h0, $past(r.id_q), 1'b0})
        else $error("bus address wrong after latch");
    cable_type_select_latch_a: assert property (
        $rose(r.latched) |-> r.dual[VLM_CABLE_TYPE_SELECT_BIT] == $past(r.s1_q[1]))
        else $error("cable strap not latched");
    latch_once_a: assert property (
        r.latched |=> r.latched && $stable(r.addr))
        else $error("strap capture repeated");
    sec_only_a: assert property (
        r.latched && !auto_off && r.p_q == 3'b010 |=> r.mode == VLM_SECONDARY)
        else $error("secondary-only not chosen");
    auto_dual_a: assert property (
        r.latched && !auto_off && r.p_q[0] && r.p_q[2] && pclk_mhz_in >= VLM_DUAL_MIN_MHZ
        |=> r.mode == VLM_DUAL)
        else $error("auto dual not entered");
    pll_gate_a: assert property (
        r.pll_rst |-> $past(r.dual[VLM_PLLRST_BIT]))
        else $error("pll reset while feature off");

    dual_run_c: cover property ((r.mode == VLM_DUAL && pix_valid_in) [*2]);
    replicate_c: cover property (r.mode == VLM_REPLICATE && r.pa_vld);
    latch_c: cover property ($rose(r.latched));
    pll_c: cover property (r.pll_rst);
endmodule : vlm_mode_strap

/* File: tb/vlm_rx_model.sv */
/*
 * model of the one or two downstream receivers: detection pins and pixel capture.
 * assumes link valids are one-cycle pulses on clk_in and the bench picks attachment.
 */
`timescale 1ns/1ps
module vlm_rx_model (
    // clock and attachment chosen by the bench
    input  wire logic        clk_in,
    input  wire logic        prim_cfg_in,
    input  wire logic        sec_cfg_in,
    input  wire logic        dcap_cfg_in,
    // serial links from the bridge
    input  wire logic [23:0] link_a_data_in,
    input  wire logic        link_a_valid_in,
    input  wire logic [23:0] link_b_data_in,
    input  wire logic        link_b_valid_in,
    // detection pins and what arrived
    output logic             prim_out,
    output logic             sec_out,
    output logic             dcap_out,
    output int               cnt_a_out,
    output int               cnt_b_out,
    output logic      [23:0] last_a_out,
    output logic      [23:0] last_b_out
);
    // ------------------------------------------------------------
    // detection and capture
    // ------------------------------------------------------------
    int          ca = 0;
    int          cb = 0;
    logic [23:0] la = 24'h00_0000;
    logic [23:0] lb = 24'h00_0000;
    assign prim_out   = prim_cfg_in;
    assign sec_out    = sec_cfg_in;
    // a dual-capable report only comes from an attached primary receiver
    assign dcap_out   = dcap_cfg_in & prim_cfg_in;
    assign cnt_a_out  = ca;
    assign cnt_b_out  = cb;
    assign last_a_out = la;
    assign last_b_out = lb;
    always @(posedge clk_in) begin
        if (link_a_valid_in === 1'b1) begin
            ca <= ca + 1;
            la <= link_a_data_in;
        end
        if (link_b_valid_in === 1'b1) begin
            cb <= cb + 1;
            lb <= link_b_data_in;
        end
    end
endmodule : vlm_rx_model

/* File: tb/tb_top.sv */
/*
 * self-checking bench of the strap loader and link mode selector.
 * assumes vlm_pkg, the design and the receiver model are compiled first.
 */
`timescale 1ns/1ps
module tb_top import vlm_pkg::*;;
    typedef struct packed {
        logic       p, s, c;
        logic [7:0] mhz, ctl;
        vlm_mode_t  mode;
        logic       sen;
        logic [1:0] ea, eb;
    } vlm_row_t;
    // ------------------------------------------------------------
    // stimulus, wiring and rows
    // ------------------------------------------------------------
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pv = 1'b0;
    logic        p_cfg = 1'b0, s_cfg = 1'b0, c_cfg = 1'b0;
    logic [2:0]  fms = 3'h0, sms = 3'h0, adr = 3'h0;
    logic [7:0]  mhz = 8'h3c, ra = 8'h00, wd = 8'h00, rdata;
    logic [23:0] pd = 24'h00_0000, la_d, lb_d, last_a, last_b;
    logic        rvalid, la_v, lb_v, sen, cable_type_select, ovr, pll, latched, prim, sec, dcap;
    logic [6:0]  baddr;
    vlm_mode_t   mode;
    int          error_cnt = 0, check_count = 0, cyc = 0, cnt_a, cnt_b;
    // 60 MHz rows keep legacy single receivers in their range
    vlm_row_t rows [9] = '{
        '{1'b1, 1'b0, 1'b0, 8'h3c, 8'h00, VLM_SINGLE,    1'b1, 2'h2, 2'h0},
        '{1'b1, 1'b1, 1'b0, 8'h3c, 8'h00, VLM_REPLICATE, 1'b1, 2'h2, 2'h2},
        '{1'b1, 1'b0, 1'b1, 8'h61, 8'h00, VLM_DUAL,      1'b1, 2'h1, 2'h1},
        '{1'b1, 1'b0, 1'b1, 8'h60, 8'h00, VLM_SINGLE,    1'b1, 2'h2, 2'h0},
        '{1'b0, 1'b1, 1'b0, 8'h3c, 8'h00, VLM_SECONDARY, 1'b1, 2'h0, 2'h2},
        '{1'b0, 1'b0, 1'b0, 8'h3c, 8'h00, VLM_IDLE,      1'b1, 2'h0, 2'h0},
        '{1'b0, 1'b0, 1'b0, 8'h3c, 8'h05, VLM_SINGLE,    1'b0, 2'h2, 2'h0},
        '{1'b0, 1'b0, 1'b0, 8'haa, 8'h06, VLM_DUAL,      1'b1, 2'h1, 2'h1},
        '{1'b1, 1'b1, 1'b0, 8'h3c, 8'h04, VLM_SINGLE,    1'b1, 2'h2, 2'h0}};
    always #2 clk = ~clk;
    vlm_mode_strap DUT (
        .clk_in(clk), .resetn_in(rstn), .first_mode_strap_in(fms),
        .second_mode_strap_in(sms), .address_strap_pin_in(adr),
        .rx_primary_present_in(prim), .rx_secondary_present_in(sec),
        .rx_dual_capable_in(dcap), .pclk_mhz_in(mhz), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .pix_data_in(pd), .pix_valid_in(pv),
        .link_a_data_out(la_d), .link_a_valid_out(la_v), .link_b_data_out(lb_d),
        .link_b_valid_out(lb_v), .link_mode_out(mode), .secondary_link_enable_out(sen),
        .cable_cable_type_select_out(cable_type_select), .external_input_override_out(ovr), .pll_reset_out(pll),
        .bus_address_out(baddr), .straps_latched_out(latched));
    vlm_rx_model RX (
        .clk_in(clk), .prim_cfg_in(p_cfg), .sec_cfg_in(s_cfg), .dcap_cfg_in(c_cfg),
        .link_a_data_in(la_d), .link_a_valid_in(la_v), .link_b_data_in(lb_d),
        .link_b_valid_in(lb_v), .prim_out(prim), .sec_out(sec), .dcap_out(dcap),
        .cnt_a_out(cnt_a), .cnt_b_out(cnt_b), .last_a_out(last_a), .last_b_out(last_b));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // inputs move 1 ns after the edge so the design samples settled values
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        ra = a;
        wd = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        rd = 1'b1;
        ra = a;
        tick(1);
        rd = 1'b0;
        chk("rvalid", 24'(rvalid), 24'h00_0001);
        chk("rdata", 24'(rdata), 24'(exp));
        tick(1);
    endtask : rreg
    task automatic pll_count(output int n);
        n = 0;
        repeat (10) begin
            tick(1);
            n += int'(pll === 1'b1);
        end
    endtask : pll_count
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [2:0]  l;
        logic [23:0] p0, p1;
        int          n, i, ca, cb;
        vlm_row_t    r;
        // first release with all straps low, then the ordinary rows
        tick(16);
        rstn = 1'b1;
        tick(12);
        chk("latched", 24'(latched), 24'h00_0001);
        for (i = 0; i < 9; i++) begin
            r = rows[i];
            wreg(VLM_DUAL_CTL_OFS, r.ctl);
            p_cfg = r.p;
            s_cfg = r.s;
            c_cfg = r.c;
            mhz = r.mhz;
            for (n = 0; n < 30 && mode !== r.mode; n++) begin
                tick(1);
            end
            chk("mode", 24'(mode), 24'(r.mode));
            chk("sec_enable", 24'(sen), 24'(r.sen));
            ca = cnt_a;
            cb = cnt_b;
            p0 = 24'h11_0000 | 24'(i);
            p1 = 24'h22_0000 | 24'(i);
            pv = 1'b1;
            pd = p0;
            tick(1);
            pd = p1;
            tick(1);
            pv = 1'b0;
            tick(3);
            chk("a_count", 24'(cnt_a - ca), 24'(r.ea));
            chk("b_count", 24'(cnt_b - cb), 24'(r.eb));
            if (r.ea != 2'h0) begin
                chk("a_last", last_a, (r.ea == 2'h1) ? p0 : p1);
            end
            if (r.eb != 2'h0) begin
                chk("b_last", last_b, p1);
            end
        end
        // every level of the second mode and address straps, and levels 0 to 3 of the first, goes through its own reset and capture
        for (int v = 0; v < 8; v++) begin
            l = 3'(v);
            rstn = 1'b0;
            fms = l & 3'h3;
            sms = l;
            adr = l;
            tick(16);
            rstn = 1'b1;
            for (i = 0; i < 40 && latched !== 1'b1; i++) begin
                tick(1);
            end
            chk("latched", 24'(latched), 24'h00_0001);
            chk("bus_addr", 24'(baddr), 24'(7'h0c + 7'(2 * v)));
            rreg(VLM_BRIDGE_CONTROL_OFS, {7'h00, l[1]});
            rreg(VLM_BRIDGE_CFG_OFS, {l[2], 1'b0, l[0], 3'h0, l[0], 1'b0});
            rreg(VLM_DUAL_CTL_OFS, {l[1], 7'h20});
            chk("cable_type_select", 24'(cable_type_select), 24'(l[1]));
            chk("override", 24'(ovr), 24'(l[2]));
        end
        sms = 3'h0;
        fms = 3'h0;
        tick(10);
        rreg(VLM_BRIDGE_CFG_OFS, 8'ha2);
        rreg(VLM_DUAL_CTL_OFS, 8'ha0);
        wreg(VLM_DUAL_CTL_OFS, 8'h20);
        chk("cable_type_select", 24'(cable_type_select), 24'h00_0000);
        wreg(VLM_BRIDGE_CFG_OFS, 8'h00);
        chk("override", 24'(ovr), 24'h00_0000);
        wreg(VLM_BRIDGE_CONTROL_OFS, 8'h5a);
        rreg(VLM_BRIDGE_CONTROL_OFS, 8'h5a);
        wreg(8'h10, 8'hff);
        rreg(8'h10, 8'h00);
        mhz = 8'h3d;
        pll_count(n);
        chk("pll_pulse", 24'(n), 24'h00_0001);
        wreg(VLM_DUAL_CTL_OFS, 8'h00);
        mhz = 8'h3c;
        pll_count(n);
        chk("pll_quiet", 24'(n), 24'h00_0000);
        give_verdict();
    end
endmodule : tb_top
